// ---- core/sram_port_pkg.sv ----
// constants for the burst-of-two common-io sram port
`default_nettype none
package sram_port_pkg;
    // ========================================================
    // organisations
    localparam int DATA_W_X36  = 36;
    localparam int ADDR_W_X36  = 18;
    localparam int DATA_W_X18  = 18;
    localparam int ADDR_W_X18  = 19;
    localparam int LANE_W      = 9;
    localparam int BURST_LEN   = 2;
    // ========================================================
    // read latency in input clock cycles
    localparam int RD_LAT_DLL    = 2;
    localparam int RD_LAT_BYPASS = 1;
    // ========================================================
    // system clock
    localparam int CLK_PERIOD_NS = 10;
    // ========================================================
    // reset values
    localparam logic       RESET_OE    = 1'b0;
    localparam logic       RESET_VALID = 1'b0;
    localparam logic [1:0] RESET_PIPE  = 2'h0;
    // ========================================================
    // write sequence states
    typedef enum logic [1:0] {
        WR_IDLE    = 2'b00,
        WR_WAIT_B0 = 2'b01,
        WR_WAIT_B1 = 2'b10
    } wr_state_t;
endpackage : sram_port_pkg
`default_nettype wire

// ---- core/sram_port.sv ----
// burst-of-two double-data-rate common-io sram port with its array
`timescale 1ns/100ps
`default_nettype none

module sram_port
    import sram_port_pkg::*;
#(
    parameter int DATA_W = DATA_W_X36,
    parameter int ADDR_W = ADDR_W_X36
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // input clock pair and controls
    input  wire logic              i_main_input_true,
    input  wire logic              i_main_input_comp,
    input  wire logic              i_load_strobe_n,
    input  wire logic              i_access_dir,
    input  wire logic [ADDR_W-1:0] i_address_in,
    input  wire logic [DATA_W/LANE_W-1:0] i_byte_write_en_n,
    input  wire logic              i_dll_bypass_n,
    // common data bus
    input  wire logic [DATA_W-1:0] i_dq,
    output var  logic [DATA_W-1:0] o_dq,
    output var  logic              o_dq_oe,
    // echo clocks and valid
    output var  logic              o_echo_true,
    output var  logic              o_echo_comp,
    output var  logic              o_output_valid
);
    localparam int LANES = DATA_W / LANE_W;
    localparam int IN_W  = 5 + ADDR_W + LANES + DATA_W;

    // ========================================================
    // byte merge
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                                input logic [DATA_W-1:0] new_w,
                                                input logic [LANES-1:0]  en_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < LANES; l++) begin
            if (!en_n[l]) begin
                res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction : merge

    // ========================================================
    // input synchronisers
    logic [IN_W-1:0] in_s1_reg;
    logic [IN_W-1:0] in_s2_reg;
    logic            k_s3_reg;
    logic            kc_s3_reg;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            in_s1_reg <= '0;
            in_s2_reg <= '0;
            k_s3_reg  <= 1'b0;
            kc_s3_reg <= 1'b0;
        end else begin
            in_s1_reg <= {i_main_input_true, i_main_input_comp, i_load_strobe_n, i_access_dir,
                          i_dll_bypass_n, i_address_in, i_byte_write_en_n, i_dq};
            in_s2_reg <= in_s1_reg;
            k_s3_reg  <= in_s2_reg[IN_W-1];
            kc_s3_reg <= in_s2_reg[IN_W-2];
        end
    end

    logic              k_s2;
    logic              kc_s2;
    logic              load_n;
    logic              dir_rd;
    logic              lat_dll;
    logic [ADDR_W-1:0] addr_s;
    logic [LANES-1:0]  bw_n_s;
    logic [DATA_W-1:0] dq_s;
    logic              k_rise;
    logic              kc_rise;
    assign {k_s2, kc_s2, load_n, dir_rd, lat_dll, addr_s, bw_n_s, dq_s} = in_s2_reg;
    assign k_rise  = k_s2 && !k_s3_reg;
    assign kc_rise = kc_s2 && !kc_s3_reg;

    // ========================================================
    // array
    logic [DATA_W-1:0] mem [0:(2**(ADDR_W+1))-1];

    // ========================================================
    // command capture
    logic              rd_cmd;
    logic              wr_cmd;
    logic [ADDR_W-1:0] cmd_addr_reg;
    assign rd_cmd = k_rise && !load_n && dir_rd;
    assign wr_cmd = k_rise && !load_n && !dir_rd;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cmd_addr_reg <= '0;
        end else if (k_rise && !load_n) begin
            cmd_addr_reg <= addr_s;
        end
    end

    // ========================================================
    // late write buffer
    wr_state_t         wr_state_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [ADDR_W-1:0] nxt_addr_reg;
    logic              nxt_valid_reg;
    logic [DATA_W-1:0] wb0_reg;
    logic [LANES-1:0]  wbe0_reg;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_state_reg  <= WR_IDLE;
            wr_addr_reg   <= '0;
            nxt_addr_reg  <= '0;
            nxt_valid_reg <= 1'b0;
            wb0_reg       <= '0;
            wbe0_reg      <= '0;
        end else begin
            case (wr_state_reg)
                WR_IDLE: begin
                    if (wr_cmd) begin
                        wr_addr_reg  <= addr_s;
                        wr_state_reg <= WR_WAIT_B0;
                    end
                end
                WR_WAIT_B0: begin
                    if (k_rise) begin
                        wb0_reg      <= dq_s;
                        wbe0_reg     <= bw_n_s;
                        wr_state_reg <= WR_WAIT_B1;
                        if (wr_cmd) begin
                            nxt_addr_reg  <= addr_s;
                            nxt_valid_reg <= 1'b1;
                        end
                    end
                end
                WR_WAIT_B1: begin
                    if (kc_rise) begin
                        nxt_valid_reg <= 1'b0;
                        wr_addr_reg   <= nxt_addr_reg;
                        wr_state_reg  <= nxt_valid_reg ? WR_WAIT_B0 : WR_IDLE;
                    end
                end
                default: begin
                    wr_state_reg <= WR_IDLE;
                end
            endcase
        end
    end

    // commit both beats once the second beat arrives
    always_ff @(posedge i_clk) begin
        if (wr_state_reg == WR_WAIT_B1 && kc_rise) begin
            mem[{wr_addr_reg, 1'b0}] <= merge(mem[{wr_addr_reg, 1'b0}], wb0_reg, wbe0_reg);
            mem[{wr_addr_reg, 1'b1}] <= merge(mem[{wr_addr_reg, 1'b1}], dq_s, bw_n_s);
        end
    end

    // ========================================================
    // read pipeline
    logic [1:0]        rd_pipe_reg;
    logic [ADDR_W-1:0] rd_a0_reg;
    logic [ADDR_W-1:0] rd_a1_reg;
    logic              issue;
    logic [ADDR_W-1:0] issue_addr;
    assign issue      = k_rise && (lat_dll ? rd_pipe_reg[1] : rd_pipe_reg[0]);
    assign issue_addr = lat_dll ? rd_a1_reg : rd_a0_reg;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_pipe_reg <= RESET_PIPE;
            rd_a0_reg   <= '0;
            rd_a1_reg   <= '0;
        end else if (k_rise) begin
            rd_pipe_reg <= {rd_pipe_reg[0], rd_cmd};
            rd_a0_reg   <= addr_s;
            rd_a1_reg   <= rd_a0_reg;
        end
    end

    // ========================================================
    // output drive and echo clocks
    logic [DATA_W-1:0] rd_hold_reg;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_dq           <= '0;
            o_dq_oe        <= RESET_OE;
            o_output_valid <= RESET_VALID;
            rd_hold_reg    <= '0;
            o_echo_true    <= 1'b0;
            o_echo_comp    <= 1'b0;
        end else begin
            o_echo_true <= k_s2;
            o_echo_comp <= kc_s2;
            if (k_rise) begin
                // array is read at drive time so earlier writes are already committed
                o_dq           <= mem[{issue_addr, 1'b0}];
                rd_hold_reg    <= mem[{issue_addr, 1'b1}];
                o_dq_oe        <= issue;
                o_output_valid <= issue;
            end else if (kc_rise && o_dq_oe) begin
                o_dq <= rd_hold_reg;
            end
        end
    end

    // ========================================================
    // assertions
    property p_echo_aligned;
        @(posedge i_clk) disable iff (i_reset) k_rise |=> o_echo_true && (o_dq_oe == $past(issue));
    endproperty
    a_echo_aligned: assert property (p_echo_aligned) else $error("echo not aligned with data");

    property p_valid_oe;
        @(posedge i_clk) disable iff (i_reset) o_output_valid == o_dq_oe;
    endproperty
    a_valid_oe: assert property (p_valid_oe) else $error("valid differs from drive");

    property p_cmd_on_true;
        @(posedge i_clk) disable iff (i_reset) !k_rise |=> $stable(cmd_addr_reg);
    endproperty
    a_cmd_on_true: assert property (p_cmd_on_true) else $error("address taken off true rise");

    property p_read_lat2;
        @(posedge i_clk) disable iff (i_reset) k_rise && lat_dll && rd_pipe_reg[1] |=> o_dq_oe;
    endproperty
    a_read_lat2: assert property (p_read_lat2) else $error("read beat missing at latency two");

    property p_read_bypass;
        @(posedge i_clk) disable iff (i_reset) k_rise && !lat_dll && rd_pipe_reg[0] |=> o_dq_oe;
    endproperty
    a_read_bypass: assert property (p_read_bypass) else $error("read beat missing in bypass");

    property p_beat2;
        @(posedge i_clk) disable iff (i_reset) kc_rise && !k_rise && o_dq_oe |=> o_dq == $past(rd_hold_reg);
    endproperty
    a_beat2: assert property (p_beat2) else $error("second read beat wrong");

    property p_write_beat0;
        @(posedge i_clk) disable iff (i_reset)
            wr_state_reg == WR_WAIT_B0 && k_rise |=> wr_state_reg == WR_WAIT_B1 && wb0_reg == $past(dq_s);
    endproperty
    a_write_beat0: assert property (p_write_beat0) else $error("first write beat not taken");

    property p_commit;
        @(posedge i_clk) disable iff (i_reset) wr_state_reg == WR_WAIT_B1 && kc_rise |=> wr_state_reg != WR_WAIT_B1;
    endproperty
    a_commit: assert property (p_commit) else $error("write not committed");
endmodule : sram_port

`default_nettype wire

// ---- sim/ctrl_model.sv ----
// controller model: input clock pair, commands, write beats, read capture
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
    // clock
    input  wire logic        i_clk,
    // toward the port
    output var  logic        o_k,
    output var  logic        o_kn,
    output var  logic        o_load_n,
    output var  logic        o_dir,
    output var  logic [17:0] o_addr,
    output var  logic [3:0]  o_be_n,
    output var  logic [35:0] o_dq,
    // from the port
    input  wire logic [35:0] i_q,
    input  wire logic        i_q_oe,
    input  wire logic        i_echo_true,
    input  wire logic        i_echo_comp,
    input  wire logic        i_valid
);
    logic [18:0] cmd_q[$];
    logic [39:0] beat_q[$];
    logic [35:0] rd_q[$];
    int          lat_q[$];
    int          cmd_k[$];
    int          k_cnt = 0;
    logic [2:0]  phase = 3'h0;
    logic        wr_due = 1'b0;
    logic        drv = 1'b0;
    logic [35:0] drv_d = 36'h0;
    logic [35:0] prev_dq = 36'h0;
    logic        et_prev = 1'b0;
    logic        ec_prev = 1'b0;
    int          n_clash = 0;
    logic [18:0] c;
    initial begin
        {o_k, o_kn, o_load_n, o_dir} = 4'h6;
        o_addr = 18'h0;
        o_be_n = 4'hf;
    end
    // ==========
    // queue one command, a write carries both beats
    task automatic issue(input logic d, input logic [17:0] a, input logic [3:0] b0, b1, input logic [35:0] d0, d1);
        cmd_q.push_back({d, a});
        if (!d) begin
            beat_q.push_back({b0, d0});
            beat_q.push_back({b1, d1});
        end
    endtask : issue
    // ==========
    // common bus: released lines wander
    always_comb o_dq = i_q_oe ? i_q : (drv ? drv_d : ~prev_dq);
    always @(posedge i_clk) begin
        phase <= phase + 3'h1;
        prev_dq <= o_dq;
        if (drv && i_q_oe) n_clash <= n_clash + 1;
        if (phase == 3'h7) begin
            {o_k, o_kn} <= 2'h2;
            k_cnt <= k_cnt + 1;
        end
        if (phase == 3'h3) {o_k, o_kn} <= 2'h1;
        if (phase == 3'h1 && drv) {o_be_n, drv_d} <= beat_q.pop_front();
        if (phase == 3'h5) begin
            drv <= wr_due;
            o_load_n <= 1'b1;
            wr_due <= 1'b0;
            if (wr_due) {o_be_n, drv_d} <= beat_q.pop_front();
            if (cmd_q.size() > 0) begin
                c = cmd_q.pop_front();
                {o_dir, o_addr} <= c;
                o_load_n <= 1'b0;
                wr_due <= !c[18];
                if (c[18]) cmd_k.push_back(k_cnt + 1);
            end
        end
        et_prev <= i_echo_true;
        ec_prev <= i_echo_comp;
        if (i_echo_true && !et_prev && i_valid) begin
            rd_q.push_back(i_q);
            lat_q.push_back(k_cnt - cmd_k.pop_front());
        end
        if (i_echo_comp && !ec_prev && i_valid) rd_q.push_back(i_q);
    end
endmodule : ctrl_model
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the sram port
`timescale 1ns/100ps
`default_nettype none
module tb
    import sram_port_pkg::*;
;
    logic             i_clk = 1'b0;
    logic             i_reset = 1'b1;
    logic             i_dll_bypass_n = 1'b1;
    wire logic        k, kn, load_n, dir, oe, et, ec, vld;
    wire logic [17:0] addr;
    wire logic [3:0]  be_n;
    wire logic [35:0] dq_in, q;
    int               n_mismatch = 0;
    int               num_checks = 0;
    logic [35:0]      mem[int];
    logic [35:0]      exp_q[$];
    initial forever #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;
    sram_port sram_port_inst (.i_clk(i_clk), .i_reset(i_reset), .i_main_input_true(k),
        .i_main_input_comp(kn), .i_load_strobe_n(load_n), .i_access_dir(dir), .i_address_in(addr),
        .i_byte_write_en_n(be_n), .i_dll_bypass_n(i_dll_bypass_n), .i_dq(dq_in), .o_dq(q),
        .o_dq_oe(oe), .o_echo_true(et), .o_echo_comp(ec), .o_output_valid(vld));
    ctrl_model ctrl_model_inst (.i_clk(i_clk), .o_k(k), .o_kn(kn), .o_load_n(load_n), .o_dir(dir),
        .o_addr(addr), .o_be_n(be_n), .o_dq(dq_in), .i_q(q), .i_q_oe(oe), .i_echo_true(et),
        .i_echo_comp(ec), .i_valid(vld));
    // ==========
    // shared tasks
    task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic wr(input logic [17:0] a, input logic [3:0] b0, b1, input logic [35:0] d0, d1);
        for (int i = 0; i < 36; i++) begin
            if (!b0[i / 9]) mem[{a, 1'b0}][i] = d0[i];
            if (!b1[i / 9]) mem[{a, 1'b1}][i] = d1[i];
        end
        ctrl_model_inst.issue(1'b0, a, b0, b1, d0, d1);
    endtask : wr
    task automatic rd(input logic [17:0] a);
        exp_q.push_back(mem[{a, 1'b0}]);
        exp_q.push_back(mem[{a, 1'b1}]);
        ctrl_model_inst.issue(1'b1, a, 4'hf, 4'hf, 36'h0, 36'h0);
    endtask : rd
    task automatic drain(input int lat);
        int n;
        n = 0;
        while (ctrl_model_inst.rd_q.size() < exp_q.size() && n < 600) begin
            @(posedge i_clk);
            n++;
        end
        if (ctrl_model_inst.rd_q.size() < exp_q.size()) begin
            $display("unexpected read words expected %0d seen %0d", exp_q.size(), ctrl_model_inst.rd_q.size());
            n_mismatch++;
            results();
        end else begin
            while (exp_q.size() > 0) begin
                chk("read word", exp_q.pop_front(), ctrl_model_inst.rd_q.pop_front());
            end
            while (ctrl_model_inst.lat_q.size() > 0) begin
                chk("latency", 36'(lat), 36'(ctrl_model_inst.lat_q.pop_front()));
            end
            repeat (16) @(posedge i_clk);
            chk("oe idle", 36'h0, {35'h0, oe});
            chk("valid idle", 36'h0, {35'h0, vld});
            chk("bus clash", 36'h0, 36'(ctrl_model_inst.n_clash));
        end
    endtask : drain
    // ==========
    // scenarios
    task automatic s_reset;
        chk("oe reset", {35'h0, RESET_OE}, {35'h0, oe});
        chk("valid reset", {35'h0, RESET_VALID}, {35'h0, vld});
    endtask : s_reset
    task automatic s_basic;
        wr(18'h00010, 4'h0, 4'h0, 36'h123456789, 36'hfedcba987);
        rd(18'h00010);
        drain(RD_LAT_DLL);
    endtask : s_basic
    task automatic s_lanes;
        wr(18'h3ffff, 4'h0, 4'h0, 36'h0, 36'h0);
        wr(18'h3ffff, 4'h5, 4'ha, 36'hfffffffff, 36'h5a5a5a5a5);
        rd(18'h3ffff);
        drain(RD_LAT_DLL);
    endtask : s_lanes
    task automatic s_b2b;
        wr(18'h00020, 4'h0, 4'h0, 36'h0a0b0c0d0, 36'h111122223);
        rd(18'h00020);
        rd(18'h00010);
        drain(RD_LAT_DLL);
    endtask : s_b2b
    task automatic s_bypass;
        i_dll_bypass_n <= 1'b0;
        repeat (16) @(posedge i_clk);
        rd(18'h3ffff);
        rd(18'h00020);
        drain(RD_LAT_BYPASS);
        i_dll_bypass_n <= 1'b1;
        repeat (16) @(posedge i_clk);
        rd(18'h00010);
        drain(RD_LAT_DLL);
    endtask : s_bypass
    initial begin
        repeat (2) @(posedge i_clk);
        s_reset();
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        s_basic();
        s_lanes();
        s_b2b();
        s_bypass();
        results();
    end
endmodule : tb
`default_nettype wire
